// *** tal_defines.svh ***
/*
 Constants of the temperature alarm limit block: pointers, field positions,
 reset values and hysteresis steps.
 Assumes it is included by its bare name from the link and limit modules.
*/
`ifndef TAL_DEFINES_SVH
`define TAL_DEFINES_SVH

// ==========================================================================
// Register pointers
`define TAL_PTR_UPPER 8'h02
`define TAL_PTR_LOWER 8'h03
`define TAL_PTR_CRIT 8'h04
`define TAL_PTR_TEMP 8'h05
`define TAL_PTR_MAKER 8'h06

// ==========================================================================
// Field positions and masks
`define TAL_LIM_MASK 16'h1FFC
`define TAL_LIM_SIGN 12
`define TAL_LIM_LSB 2
`define TAL_TEMP_LSB 1
`define TAL_BIT_CRIT 15
`define TAL_BIT_UPPER 14
`define TAL_BIT_LOWER 13

// ==========================================================================
// Reset values
`define TAL_LIM_RST 16'h0000
`define TAL_TEMP_RST 12'h000
`define TAL_RDATA_RST 16'h0000

// ==========================================================================
// Hysteresis in steps of 0.125 degrees: 0, 1.5, 3 and 6 degrees
`define TAL_HYST_ZERO 13'h0000
`define TAL_HYST_1P5 13'h000C
`define TAL_HYST_3 13'h0018
`define TAL_HYST_6 13'h0030

`endif

// *** tal_pkg.sv ***
/*
 Types shared by the temperature alarm limit block.
 Assumes tal_defines.svh is on the include path.
*/
package tal_pkg;

	// ======================================================================
	// Hysteresis selection
	typedef enum logic [1:0] {
		TAL_HYST_OFF = 2'h0,
		TAL_HYST_SMALL = 2'h1,
		TAL_HYST_MID = 2'h2,
		TAL_HYST_LARGE = 2'h3
	} tal_hyst_t;

	// ======================================================================
	// Link side transfer states
	typedef enum logic [1:0] {
		TAL_LINK_IDLE = 2'b01,
		TAL_LINK_WAIT = 2'b10
	} tal_link_state_t;

endpackage

// *** tal_xfer_if.sv ***
/*
 Carries one register access between the link clock domain and the
 reference clock domain as a toggle handshake.
 Assumes ptr, wr and wdata stay still between a request toggle and its ack.
*/
`timescale 1ns/1ps
interface tal_xfer_if #(parameter int PTR_W = 8);
	logic req_tgl;
	logic ack_tgl;
	logic wr;
	logic [PTR_W-1:0] ptr;
	logic [15:0] wdata;
	logic [15:0] rdata;

	modport link (output req_tgl, output wr, output ptr, output wdata,
		input ack_tgl, input rdata);
	modport core (input req_tgl, input wr, input ptr, input wdata,
		output ack_tgl, output rdata);
endinterface

// *** tal_link.sv ***
/*
 Link clock side of the register access path: takes a read or write strobe,
 raises a request toggle and returns read data when the ack toggle arrives.
 Assumes strobes and data come from logic on LINK_CLK.
*/
`timescale 1ns/1ps
`include "tal_defines.svh"
module tal_link
	import tal_pkg::*;
#(
	parameter int PTR_W = 8
)
(
	input wire logic link_clk, // Link clock.
	input wire logic link_reset_n, // Synchronous reset, active low.
	input wire logic wr_stb, // Write request pulse.
	input wire logic rd_stb, // Read request pulse.
	input wire logic [PTR_W-1:0] ptr, // Register pointer.
	input wire logic [15:0] wdata, // Write data.
	output logic [15:0] rdata, // Read data of the last access.
	output logic done, // Access finished pulse.
	output logic busy, // Access in flight.
	tal_xfer_if.link xfer // Handshake towards the core.
);
	tal_link_state_t state, next_state;
	logic req_tgl, next_req_tgl;
	logic wr, next_wr;
	logic [PTR_W-1:0] ptr_hold, next_ptr_hold;
	logic [15:0] wdata_hold, next_wdata_hold;
	logic [15:0] next_rdata;
	logic next_done, next_busy;
	logic ack_meta, ack_sync, ack_seen;

	assign xfer.req_tgl = req_tgl;
	assign xfer.wr = wr;
	assign xfer.ptr = ptr_hold;
	assign xfer.wdata = wdata_hold;

	// ======================================================================
	// Transfer control
	always_comb
	begin
		next_state = state;
		next_req_tgl = req_tgl;
		next_wr = wr;
		next_ptr_hold = ptr_hold;
		next_wdata_hold = wdata_hold;
		next_rdata = rdata;
		next_done = 1'b0;
		next_busy = busy;
		case (state)
			TAL_LINK_IDLE:
			begin
				if (wr_stb || rd_stb)
				begin
					next_wr = wr_stb;
					next_ptr_hold = ptr;
					next_wdata_hold = wdata;
					next_req_tgl = ~req_tgl;
					next_busy = 1'b1;
					next_state = TAL_LINK_WAIT;
				end
			end
			TAL_LINK_WAIT:
			begin
				// Strobes are ignored here; the held word stays still for the core.
				if (ack_sync != ack_seen)
				begin
					next_rdata = xfer.rdata;
					next_done = 1'b1;
					next_busy = 1'b0;
					next_state = TAL_LINK_IDLE;
				end
			end
			default:
			begin
				next_state = TAL_LINK_IDLE;
				next_busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge link_clk)
	begin
		if (!link_reset_n)
		begin
			state <= TAL_LINK_IDLE;
			req_tgl <= 1'b0;
			wr <= 1'b0;
			ptr_hold <= '0;
			wdata_hold <= 16'h0000;
			rdata <= `TAL_RDATA_RST;
			done <= 1'b0;
			busy <= 1'b0;
			ack_meta <= 1'b0;
			ack_sync <= 1'b0;
			ack_seen <= 1'b0;
		end
		else
		begin
			state <= next_state;
			req_tgl <= next_req_tgl;
			wr <= next_wr;
			ptr_hold <= next_ptr_hold;
			wdata_hold <= next_wdata_hold;
			rdata <= next_rdata;
			done <= next_done;
			busy <= next_busy;
			ack_meta <= xfer.ack_tgl;
			ack_sync <= ack_meta;
			ack_seen <= ack_sync;
		end
	end
endmodule // tal_link

// *** tal_limits.sv ***
/*
 Temperature alarm limit registers: upper, lower and critical limits, the
 measured temperature with its trip flags, the maker code and the alarm pin.
 Assumes conversions arrive on REF_CLK with a one-cycle valid pulse, and
 register accesses come from link logic on LINK_CLK.
*/
`timescale 1ns/1ps
`include "tal_defines.svh"

// Functional notes
// - Lower limit register at 03h, read/write
// - Alarm on below lower minus hysteresis
// - Window lock makes lower limit read-only
// - Limits: bits 15:13, 1:0 read zero
// - Critical limit register at 04h, read/write
// - Alarm above critical until at/below minus hysteresis
// - Critical lock makes critical limit read-only
// - Read-only temperature register at 05h
// - Trip bits independent of alarm pin; the pin takes bit 14 (above upper) directly
// - Bit 15: at/above critical, hysteresis clear
// - Bit 14: above upper, hysteresis clear
// - Bit 13: below lower, clears at/above
// - Temperature bit 12 sign, 11:1 value
// - Temperature and limit weights compare directly
// - Read-only maker code at 06h
// - Upper limit register at 02h
// - Alarm only while output enable set
// - Critical-only mode ignores window trips
// - Lock bits clear only by reset
module tal_limits
	import tal_pkg::*;
#(
	parameter logic [15:0] MAKER_ID = 16'h0A5C, // Arbitrary value.
	parameter int PTR_W = 8
)
(
	input wire logic REF_CLK, // Core clock, 10 MHz.
	input wire logic RESET_N, // Synchronous power-on reset, active low.
	input wire logic LINK_CLK, // Link clock.
	input wire logic LINK_RESET_N, // Synchronous link reset, active low.
	input wire logic LINK_WR_STB, // Register write pulse.
	input wire logic LINK_RD_STB, // Register read pulse.
	input wire logic [PTR_W-1:0] LINK_PTR, // Register pointer.
	input wire logic [15:0] LINK_WDATA, // Write data.
	output logic [15:0] LINK_RDATA, // Read data.
	output logic LINK_DONE, // Access finished pulse.
	output logic LINK_BUSY, // Access in flight.
	input wire logic [11:0] TEMP_CODE, // New measurement, eighths of a degree.
	input wire logic TEMP_VALID, // Conversion finished pulse.
	input wire logic ALARM_OUT_EN, // Alarm output enable.
	input wire logic CRIT_ONLY, // Alarm on critical trip only.
	input wire logic WIN_LOCK_SET, // Sets the window limit lock.
	input wire logic CRIT_LOCK_SET, // Sets the critical limit lock.
	input wire tal_hyst_t HYST_SEL, // Hysteresis selection.
	output logic ALARM_OUT, // Alarm pin, active high.
	output logic WIN_LOCKED, // Window limit lock state.
	output logic CRIT_LOCKED // Critical limit lock state.
);
	generate
		if (PTR_W < 3 || PTR_W > 8)
		begin : bad_ptr_w
			$error("PTR_W must lie between 3 and 8");
		end
	endgenerate

	tal_xfer_if #(.PTR_W(PTR_W)) xfer ();

	tal_link #(.PTR_W(PTR_W)) link_side (
		.link_clk(LINK_CLK),
		.link_reset_n(LINK_RESET_N),
		.wr_stb(LINK_WR_STB),
		.rd_stb(LINK_RD_STB),
		.ptr(LINK_PTR),
		.wdata(LINK_WDATA),
		.rdata(LINK_RDATA),
		.done(LINK_DONE),
		.busy(LINK_BUSY),
		.xfer(xfer.link)
	);

	// ======================================================================
	// Request crossing into the core domain
	logic req_meta, req_sync, req_seen;
	logic new_req;
	logic [7:0] ptr;

	assign new_req = req_sync ^ req_seen;
	assign ptr = 8'(xfer.ptr);

	// ======================================================================
	// Register state
	logic [15:0] upper_limit_value, next_upper_limit_value;
	logic [15:0] lower_limit_value, next_lower_limit_value;
	logic [15:0] critical_limit_value, next_critical_limit_value;
	logic [11:0] temp_code, next_temp_code;
	logic critical_exceeded_flag, next_critical_exceeded_flag;
	logic above_upper_flag, next_above_upper_flag;
	logic below_lower_flag, next_below_lower_flag;
	logic crit_alarm, next_crit_alarm;
	logic low_alarm, next_low_alarm;
	logic next_alarm_out;
	logic next_win_locked, next_crit_locked;
	logic ack_tgl, next_ack_tgl;
	logic [15:0] rdata, next_rdata;
	logic [15:0] temperature_reading;
	logic [15:0] read_mux;

	assign xfer.ack_tgl = ack_tgl;
	assign xfer.rdata = rdata;

	// Trip bits 15 and 13 are kept apart from the alarm path; bit 14 feeds it.
	assign temperature_reading = {critical_exceeded_flag, above_upper_flag,
		below_lower_flag, temp_code, 1'b0};

	// ======================================================================
	// Comparison operands in signed eighths of a degree
	logic signed [12:0] t_now;
	logic signed [12:0] up_lim, low_lim, crit_lim;
	logic signed [12:0] hyst;
	logic signed [12:0] up_rel, low_rel, crit_rel;

	// Limit bits 12:2 carry the same weights as temperature bits 12:2.
	assign t_now = {TEMP_CODE[11], TEMP_CODE};
	assign up_lim = {upper_limit_value[`TAL_LIM_SIGN],
		upper_limit_value[`TAL_LIM_SIGN:`TAL_LIM_LSB], 1'b0};
	assign low_lim = {lower_limit_value[`TAL_LIM_SIGN],
		lower_limit_value[`TAL_LIM_SIGN:`TAL_LIM_LSB], 1'b0};
	assign crit_lim = {critical_limit_value[`TAL_LIM_SIGN],
		critical_limit_value[`TAL_LIM_SIGN:`TAL_LIM_LSB], 1'b0};

	always_comb
	begin
		case (HYST_SEL)
			TAL_HYST_OFF: hyst = `TAL_HYST_ZERO;
			TAL_HYST_SMALL: hyst = `TAL_HYST_1P5;
			TAL_HYST_MID: hyst = `TAL_HYST_3;
			TAL_HYST_LARGE: hyst = `TAL_HYST_6;
			default: hyst = `TAL_HYST_ZERO;
		endcase
	end

	assign up_rel = 13'(up_lim - hyst);
	assign low_rel = 13'(low_lim - hyst);
	assign crit_rel = 13'(crit_lim - hyst);

	// ======================================================================
	// Read multiplexer
	always_comb
	begin
		case (ptr)
			`TAL_PTR_UPPER: read_mux = upper_limit_value;
			`TAL_PTR_LOWER: read_mux = lower_limit_value;
			`TAL_PTR_CRIT: read_mux = critical_limit_value;
			`TAL_PTR_TEMP: read_mux = temperature_reading;
			`TAL_PTR_MAKER: read_mux = MAKER_ID;
			default: read_mux = 16'h0000;
		endcase
	end

	// ======================================================================
	// Register writes and locks
	always_comb
	begin
		next_upper_limit_value = upper_limit_value;
		next_lower_limit_value = lower_limit_value;
		next_critical_limit_value = critical_limit_value;
		// Locks only ever set here; the reset branch alone clears them.
		next_win_locked = WIN_LOCKED | WIN_LOCK_SET;
		next_crit_locked = CRIT_LOCKED | CRIT_LOCK_SET;
		next_ack_tgl = ack_tgl;
		next_rdata = rdata;
		if (new_req)
		begin
			// Read data is the register content before any write of this access.
			next_rdata = read_mux;
			next_ack_tgl = ~ack_tgl;
			if (xfer.wr)
			begin
				case (ptr)
					`TAL_PTR_UPPER:
					begin
						if (!WIN_LOCKED)
						begin
							next_upper_limit_value = xfer.wdata & `TAL_LIM_MASK;
						end
					end
					`TAL_PTR_LOWER:
					begin
						if (!WIN_LOCKED)
						begin
							next_lower_limit_value = xfer.wdata & `TAL_LIM_MASK;
						end
					end
					`TAL_PTR_CRIT:
					begin
						if (!CRIT_LOCKED)
						begin
							next_critical_limit_value = xfer.wdata & `TAL_LIM_MASK;
						end
					end
					default:
					begin
						// Temperature, maker code and unmapped pointers ignore writes.
						next_rdata = read_mux;
					end
				endcase
			end
		end
	end

	// ======================================================================
	// Trip evaluation at each conversion
	always_comb
	begin
		next_temp_code = temp_code;
		next_critical_exceeded_flag = critical_exceeded_flag;
		next_above_upper_flag = above_upper_flag;
		next_below_lower_flag = below_lower_flag;
		next_crit_alarm = crit_alarm;
		next_low_alarm = low_alarm;
		if (TEMP_VALID)
		begin
			next_temp_code = TEMP_CODE;
			if (t_now >= crit_lim)
			begin
				next_critical_exceeded_flag = 1'b1;
			end
			else if (t_now <= crit_rel)
			begin
				next_critical_exceeded_flag = 1'b0;
			end
			if (t_now > up_lim)
			begin
				next_above_upper_flag = 1'b1;
			end
			else if (t_now <= up_rel)
			begin
				next_above_upper_flag = 1'b0;
			end
			if (t_now < low_lim)
			begin
				next_below_lower_flag = 1'b1;
			end
			else
			begin
				next_below_lower_flag = 1'b0;
			end
			if (t_now > crit_lim)
			begin
				next_crit_alarm = 1'b1;
			end
			else if (t_now <= crit_rel)
			begin
				next_crit_alarm = 1'b0;
			end
			if (t_now < low_rel)
			begin
				next_low_alarm = 1'b1;
			end
			else if (t_now >= low_lim)
			begin
				next_low_alarm = 1'b0;
			end
		end
	end

	// ======================================================================
	// Alarm pin
	always_comb
	begin
		next_alarm_out = 1'b0;
		if (ALARM_OUT_EN)
		begin
			if (CRIT_ONLY)
			begin
				next_alarm_out = crit_alarm;
			end
			else
			begin
				next_alarm_out = crit_alarm | above_upper_flag | low_alarm;
			end
		end
	end

	// ======================================================================
	// State registers
	always_ff @(posedge REF_CLK)
	begin
		if (!RESET_N)
		begin
			req_meta <= 1'b0;
			req_sync <= 1'b0;
			req_seen <= 1'b0;
			upper_limit_value <= `TAL_LIM_RST;
			lower_limit_value <= `TAL_LIM_RST;
			critical_limit_value <= `TAL_LIM_RST;
			temp_code <= `TAL_TEMP_RST;
			critical_exceeded_flag <= 1'b0;
			above_upper_flag <= 1'b0;
			below_lower_flag <= 1'b0;
			crit_alarm <= 1'b0;
			low_alarm <= 1'b0;
			ALARM_OUT <= 1'b0;
			WIN_LOCKED <= 1'b0;
			CRIT_LOCKED <= 1'b0;
			ack_tgl <= 1'b0;
			rdata <= `TAL_RDATA_RST;
		end
		else
		begin
			req_meta <= xfer.req_tgl;
			req_sync <= req_meta;
			req_seen <= req_sync;
			upper_limit_value <= next_upper_limit_value;
			lower_limit_value <= next_lower_limit_value;
			critical_limit_value <= next_critical_limit_value;
			temp_code <= next_temp_code;
			critical_exceeded_flag <= next_critical_exceeded_flag;
			above_upper_flag <= next_above_upper_flag;
			below_lower_flag <= next_below_lower_flag;
			crit_alarm <= next_crit_alarm;
			low_alarm <= next_low_alarm;
			ALARM_OUT <= next_alarm_out;
			WIN_LOCKED <= next_win_locked;
			CRIT_LOCKED <= next_crit_locked;
			ack_tgl <= next_ack_tgl;
			rdata <= next_rdata;
		end
	end
endmodule // tal_limits

// *** tal_limits_assertions.sv ***
/*
 Concurrent checks on the ports of the temperature alarm limit block.
 Assumes it is bound to tal_limits; both resets are synchronous, active low.
*/
`timescale 1ns/1ps
module tal_limits_assertions
(
	input wire logic REF_CLK, // Core clock.
	input wire logic RESET_N, // Core reset, active low.
	input wire logic LINK_CLK, // Link clock.
	input wire logic LINK_RESET_N, // Link reset, active low.
	input wire logic LINK_WR_STB, // Write pulse.
	input wire logic LINK_RD_STB, // Read pulse.
	input wire logic [15:0] LINK_RDATA, // Read data.
	input wire logic LINK_DONE, // Access finished.
	input wire logic LINK_BUSY, // Access in flight.
	input wire logic TEMP_VALID, // Conversion pulse.
	input wire logic ALARM_OUT_EN, // Alarm enable.
	input wire logic CRIT_ONLY, // Critical-only mode.
	input wire logic WIN_LOCK_SET, // Window lock request.
	input wire logic CRIT_LOCK_SET, // Critical lock request.
	input wire logic ALARM_OUT, // Alarm pin.
	input wire logic WIN_LOCKED, // Window lock state.
	input wire logic CRIT_LOCKED // Critical lock state.
);

	// ======================================================================
	// Core domain
	a_alarm_needs_en: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		ALARM_OUT |-> $past(ALARM_OUT_EN)) else $error("alarm pin high without enable");
	// The pin may only rise after a conversion or a change of enable or mode.
	a_alarm_rise_cause: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		$rose(ALARM_OUT) |-> $past(TEMP_VALID, 2) || !$past(ALARM_OUT_EN, 2)
		|| $past(CRIT_ONLY, 2)) else $error("alarm pin rose without cause");
	a_win_lock_take: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		WIN_LOCK_SET |=> WIN_LOCKED) else $error("window lock not taken");
	a_win_lock_hold: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		WIN_LOCKED |=> WIN_LOCKED) else $error("window lock dropped");
	a_crit_lock_take: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		CRIT_LOCK_SET |=> CRIT_LOCKED) else $error("critical lock not taken");
	a_crit_lock_hold: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		CRIT_LOCKED |=> CRIT_LOCKED) else $error("critical lock dropped");

	// ======================================================================
	// Link domain
	a_access_answered: assert property (@(posedge LINK_CLK) disable iff (!LINK_RESET_N)
		(LINK_WR_STB || LINK_RD_STB) && !LINK_BUSY |=> LINK_BUSY ##[1:40] LINK_DONE)
		else $error("access not answered");
	a_busy_ends_done: assert property (@(posedge LINK_CLK) disable iff (!LINK_RESET_N)
		$fell(LINK_BUSY) |-> LINK_DONE) else $error("busy fell without done");
	a_done_one_pulse: assert property (@(posedge LINK_CLK) disable iff (!LINK_RESET_N)
		LINK_DONE |=> !LINK_DONE) else $error("done longer than one cycle");
	a_rdata_only_done: assert property (@(posedge LINK_CLK) disable iff (!LINK_RESET_N)
		$changed(LINK_RDATA) |-> LINK_DONE) else $error("read data moved without done");

	c_alarm_rise: cover property (@(posedge REF_CLK) disable iff (!RESET_N) $rose(ALARM_OUT));
	c_both_locked: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
		WIN_LOCKED && CRIT_LOCKED);
	c_access_done: cover property (@(posedge LINK_CLK) disable iff (!LINK_RESET_N) LINK_DONE);

endmodule // tal_limits_assertions

bind tal_limits tal_limits_assertions tal_limits_assertions_i (.REF_CLK(REF_CLK),
	.RESET_N(RESET_N), .LINK_CLK(LINK_CLK), .LINK_RESET_N(LINK_RESET_N),
	.LINK_WR_STB(LINK_WR_STB), .LINK_RD_STB(LINK_RD_STB), .LINK_RDATA(LINK_RDATA),
	.LINK_DONE(LINK_DONE), .LINK_BUSY(LINK_BUSY), .TEMP_VALID(TEMP_VALID),
	.ALARM_OUT_EN(ALARM_OUT_EN), .CRIT_ONLY(CRIT_ONLY), .WIN_LOCK_SET(WIN_LOCK_SET),
	.CRIT_LOCK_SET(CRIT_LOCK_SET), .ALARM_OUT(ALARM_OUT), .WIN_LOCKED(WIN_LOCKED),
	.CRIT_LOCKED(CRIT_LOCKED));

// *** tal_host_model.sv ***
/*
 Bus host model: issues one register access at a time on the link side.
 Assumes a free-running link clock and the block's done pulse.
*/
`timescale 1ns/1ps
module tal_host_model
(
	input wire logic link_clk, // Link clock.
	input wire logic [15:0] rdata, // Read data from the block.
	input wire logic done, // Access finished pulse.
	output logic wr_stb, // Write pulse.
	output logic rd_stb, // Read pulse.
	output logic [7:0] ptr, // Register pointer.
	output logic [15:0] wdata // Write data.
);
	initial
	begin
		wr_stb = 1'h0;
		rd_stb = 1'h0;
		ptr = 8'h00;
		wdata = 16'h0000;
	end

	// ======================================================================
	// One access; released lines carry inverted junk so stale values never pass.
	task automatic access(input logic w, input logic [7:0] p, input logic [15:0] d,
		output logic [15:0] q);
		int n;
		@(posedge link_clk);
		wr_stb <= w;
		rd_stb <= !w;
		ptr <= p;
		wdata <= d;
		@(posedge link_clk);
		wr_stb <= 1'h0;
		rd_stb <= 1'h0;
		ptr <= ~p;
		wdata <= ~d;
		n = 0;
		while (done !== 1'h1 && n < 60)
		begin
			@(posedge link_clk);
			n++;
		end
		q = (n < 60) ? rdata : 16'hXXXX;
	endtask
endmodule // tal_host_model

// *** tal_limits_bench.sv ***
/*
 Self-checking bench of the temperature alarm limit block.
 Assumes tal_host_model drives the link side and the checker is bound.
*/
`timescale 1ns/1ps
module tal_limits_bench
	import tal_pkg::*;
;
	localparam logic [15:0] maker_code = 16'h3C96; // Arbitrary value.
	logic ref_clk = 1'h0;
	logic link_clk = 1'h0;
	logic rst_n = 1'h0;
	logic link_rst_n = 1'h0;
	logic tvalid = 1'h0;
	logic en = 1'h0;
	logic crit_only = 1'h0;
	logic win_set = 1'h0;
	logic crit_set = 1'h0;
	logic [11:0] tcode = 12'h000;
	tal_hyst_t hyst = TAL_HYST_SMALL;
	logic wr_stb, rd_stb, done, busy, alarm, win_locked, crit_locked;
	logic [7:0] ptr;
	logic [15:0] wdata, rdata;
	int error_cnt = 0;
	int compares = 0;
	int cycles = 0;

	always #50 ref_clk = ~ref_clk;
	always #15 link_clk = ~link_clk;

	tal_limits #(.MAKER_ID(maker_code)) tal_limits_i (.REF_CLK(ref_clk), .RESET_N(rst_n),
		.LINK_CLK(link_clk), .LINK_RESET_N(link_rst_n), .LINK_WR_STB(wr_stb),
		.LINK_RD_STB(rd_stb), .LINK_PTR(ptr), .LINK_WDATA(wdata), .LINK_RDATA(rdata),
		.LINK_DONE(done), .LINK_BUSY(busy), .TEMP_CODE(tcode), .TEMP_VALID(tvalid),
		.ALARM_OUT_EN(en), .CRIT_ONLY(crit_only), .WIN_LOCK_SET(win_set),
		.CRIT_LOCK_SET(crit_set), .HYST_SEL(hyst), .ALARM_OUT(alarm),
		.WIN_LOCKED(win_locked), .CRIT_LOCKED(crit_locked));
	tal_host_model tal_host_model_i (.link_clk(link_clk), .rdata(rdata), .done(done),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .ptr(ptr), .wdata(wdata));

	// ======================================================================
	// Compare and drive helpers
	task check16(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task check1(input string what, input logic exp, input logic got);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %b, seen %b", what, exp, got);
		end
	endtask

	task acc(input logic w, input logic [7:0] p, input logic [15:0] d, input logic [15:0] exp);
		logic [15:0] q;
		tal_host_model_i.access(w, p, d, q);
		check16($sformatf("data at pointer %h", p), exp, q);
	endtask

	// One conversion, then the pin and the temperature register are judged.
	task conv(input logic [11:0] c, input logic [15:0] r, input logic a);
		@(posedge ref_clk);
		tcode <= c;
		tvalid <= 1'h1;
		@(posedge ref_clk);
		tvalid <= 1'h0;
		@(posedge ref_clk);
		#1;
		check1("alarm pin", a, alarm);
		acc(1'h0, 8'h05, 16'h0000, r);
	endtask

	task en_step(input logic e, input logic a);
		@(posedge ref_clk);
		en <= e;
		@(posedge ref_clk);
		#1;
		check1("alarm pin", a, alarm);
	endtask

	// ======================================================================
	// Scenarios
	task t_limit_rw;
		acc(1'h0, 8'h06, 16'h0000, maker_code);
		acc(1'h1, 8'h03, 16'hFFFF, 16'h0000);
		acc(1'h0, 8'h03, 16'h0000, 16'h1FFC);
		acc(1'h1, 8'h04, 16'hE123, 16'h0000);
		acc(1'h0, 8'h04, 16'h0000, 16'h0120);
		acc(1'h1, 8'h05, 16'hFFFF, 16'h0000);
		acc(1'h1, 8'h06, 16'h0000, maker_code);
		acc(1'h0, 8'h06, 16'h0000, maker_code);
		acc(1'h1, 8'h07, 16'hFFFF, 16'h0000);
		acc(1'h0, 8'h07, 16'h0000, 16'h0000);
		acc(1'h1, 8'h02, 16'h0280, 16'h0000);
		acc(1'h1, 8'h03, 16'h00A0, 16'h1FFC);
		acc(1'h1, 8'h04, 16'h0500, 16'h0120);
		$display("test limit_rw done");
	endtask

	task t_window;
		conv(12'h0A0, 16'h0140, 1'h0);
		conv(12'h050, 16'h00A0, 1'h0);
		conv(12'h04F, 16'h209E, 1'h0);
		conv(12'h043, 16'h2086, 1'h1);
		conv(12'h04F, 16'h209E, 1'h1);
		conv(12'h050, 16'h00A0, 1'h0);
		conv(12'h141, 16'h4282, 1'h1);
		conv(12'h135, 16'h426A, 1'h1);
		conv(12'h134, 16'h0268, 1'h0);
		conv(12'hF60, 16'h3EC0, 1'h1);
		conv(12'h0A0, 16'h0140, 1'h0);
		$display("test window done");
	endtask

	task t_critical;
		@(posedge ref_clk);
		crit_only <= 1'h1;
		conv(12'h280, 16'hC500, 1'h0);
		conv(12'h281, 16'hC502, 1'h1);
		conv(12'h275, 16'hC4EA, 1'h1);
		conv(12'h274, 16'h44E8, 1'h0);
		conv(12'h2BC, 16'hC578, 1'h1);
		en_step(1'h0, 1'h0);
		conv(12'h2BC, 16'hC578, 1'h0);
		en_step(1'h1, 1'h1);
		@(posedge ref_clk);
		crit_only <= 1'h0;
		conv(12'h0A0, 16'h0140, 1'h0);
		$display("test critical done");
	endtask

	// The large, mid and off hysteresis steps each move the point where the above-upper flag clears.
	task t_hyst;
		@(posedge ref_clk);
		hyst <= TAL_HYST_LARGE;
		conv(12'h141, 16'h4282, 1'h1);
		conv(12'h111, 16'h4222, 1'h1);
		conv(12'h110, 16'h0220, 1'h0);
		@(posedge ref_clk);
		hyst <= TAL_HYST_MID;
		conv(12'h141, 16'h4282, 1'h1);
		conv(12'h129, 16'h4252, 1'h1);
		conv(12'h128, 16'h0250, 1'h0);
		@(posedge ref_clk);
		hyst <= TAL_HYST_OFF;
		conv(12'h141, 16'h4282, 1'h1);
		conv(12'h140, 16'h0280, 1'h0);
		conv(12'h04F, 16'h209E, 1'h1);
		conv(12'h050, 16'h00A0, 1'h0);
		$display("test hyst done");
	endtask

	task t_locks;
		@(posedge ref_clk);
		win_set <= 1'h1;
		@(posedge ref_clk);
		win_set <= 1'h0;
		#1;
		check1("window lock", 1'h1, win_locked);
		acc(1'h1, 8'h03, 16'h0123, 16'h00A0);
		acc(1'h0, 8'h03, 16'h0000, 16'h00A0);
		acc(1'h1, 8'h04, 16'h0600, 16'h0500);
		@(posedge ref_clk);
		crit_set <= 1'h1;
		@(posedge ref_clk);
		crit_set <= 1'h0;
		#1;
		check1("critical lock", 1'h1, crit_locked);
		acc(1'h1, 8'h04, 16'h0700, 16'h0600);
		acc(1'h0, 8'h04, 16'h0000, 16'h0600);
		@(posedge ref_clk);
		rst_n <= 1'h0;
		link_rst_n <= 1'h0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'h1;
		link_rst_n <= 1'h1;
		repeat (4) @(posedge ref_clk);
		check1("window lock", 1'h0, win_locked);
		check1("critical lock", 1'h0, crit_locked);
		acc(1'h0, 8'h03, 16'h0000, 16'h0000);
		$display("test locks done");
	endtask

	task close_out;
		$display("counts: %0d compares, %0d mismatches", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			error_cnt++;
			close_out;
		end
	end

	initial
	begin
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'h1;
		link_rst_n <= 1'h1;
		en <= 1'h1;
		repeat (4) @(posedge ref_clk);
		t_limit_rw;
		t_window;
		t_critical;
		t_hyst;
		t_locks;
		close_out;
	end
endmodule // tal_limits_bench
